/* ccr_regs.v */
// converter configuration register bank behind the serial register port
`timescale 1ns/100ps
`default_nettype none
`include "ccr_consts.vh"

// Summary of operation
// - mode field: 0 normal, 3 lowest-power power-down, 1 and 2 reserved.
// - low nibble of class register is a fixed read-only class code.
// - part and maker identifiers are fixed sixteen-bit read-only codes.
// - address hold set keeps the address fixed through a streaming access.
// - without hold, address steps up when order bit is 1, else down.
// - receiver enable powers the reference receiver; off after reset.
// - processor enable lets reference events be processed; off after reset.
// - fine scale bit shrinks reference window delay steps.
// - four-bit delay select picks the reference sampling delay.
// - both timestamp enables place the reference on sample LSB.
// - timestamp insertion only with down-converter bypassed.
// - two bits switch clock and reference inputs to DC-coupled mode.
// - invert bit flips the reference before alignment use.
module ccr_regs #(
  parameter [3:0] CLASS_CODE = 4'h9,    // arbitrary value
  parameter [15:0] PART_CODE = 16'h5AC3, // arbitrary value
  parameter [15:0] MAKER_CODE = 16'hA53C // arbitrary value
) (
  input wire clk_in,
  input wire sys_rst_in,
  input wire spi_cs_n_in,
  input wire spi_sclk_in,
  input wire spi_sdi_in,
  output reg spi_sdo_out,
  input wire reference_in,
  input wire general_timestamp_enable_in,
  input wire decimation_bypass_in,
  input wire [`CCR_SAMPLE_W-1:0] sample_in,
  output wire [`CCR_SAMPLE_W-1:0] sample_out,
  output wire reference_level_out,
  output wire reference_event_out,
  output wire [1:0] operating_mode_out,
  output wire normal_operation_out,
  output wire power_down_out,
  output wire reference_receiver_enable_out,
  output wire reference_processor_enable_out,
  output wire window_fine_scale_out,
  output wire [3:0] reference_delay_select_out,
  output wire clock_input_dc_mode_out,
  output wire reference_input_dc_mode_out
);

  // ==========================================================
  // frame states
  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_HEADER = 3'b010;
  localparam [2:0] ST_DATA = 3'b100;

  reg [2:0] state;
  reg [2:0] next_state;
  reg sclk_prev;
  reg [4:0] bit_cnt;
  reg [15:0] shift;
  reg read_op;
  reg [`CCR_ADDR_W-1:0] addr;
  reg [7:0] rd_shift;

  reg [7:0] config_a;
  reg [7:0] operating_mode_config;
  reg [3:0] class_reserved;
  reg [7:0] streaming_address_control;
  reg [7:0] alignment_input_control;
  reg [7:0] alignment_input_options;

  wire sclk_rise;
  wire sclk_fall;
  wire [15:0] shift_in;
  wire header_done;
  wire byte_done;
  wire [`CCR_ADDR_W-1:0] header_addr;
  wire [`CCR_ADDR_W-1:0] next_addr;
  wire [7:0] wr_data;
  wire do_write;

  assign sclk_rise = ~spi_cs_n_in & spi_sclk_in & ~sclk_prev;
  assign sclk_fall = ~spi_cs_n_in & ~spi_sclk_in & sclk_prev;
  assign shift_in = {shift[14:0], spi_sdi_in};
  assign header_done = sclk_rise & state[1] & (bit_cnt == `CCR_HEADER_BITS - 5'd1);
  assign byte_done = sclk_rise & state[2] & (bit_cnt == `CCR_FRAME_LAST_BIT);
  assign header_addr = shift_in[`CCR_ADDR_W-1:0];
  assign wr_data = shift_in[7:0];
  assign do_write = byte_done & ~read_op;

  // ==========================================================
  // streaming address step
  // hold wins over the order bit; a write to these bits first acts on the step out of the next byte
  assign next_addr = streaming_address_control[`CCR_ADDR_HOLD_BIT] ? addr :
                     config_a[`CCR_CFGA_ADDR_ORDER_BIT] ? addr + 15'h0001 :
                     addr - 15'h0001;

  // ==========================================================
  // read mux; unmapped addresses read zero
  function [7:0] read_byte;
    input [`CCR_ADDR_W-1:0] a;
    begin
      case (a)
        `CCR_ADDR_CONFIG_A: begin
          read_byte = (config_a & `CCR_CFGA_WRITE_MASK) | 8'h10;
        end
        `CCR_ADDR_OPERATING_MODE_CONFIG: begin
          read_byte = operating_mode_config;
        end
        `CCR_ADDR_DEVICE_CLASS_CODE: begin
          read_byte = {class_reserved, CLASS_CODE};
        end
        `CCR_ADDR_PART_IDENTIFIER_LO: begin
          read_byte = PART_CODE[7:0];
        end
        `CCR_ADDR_PART_IDENTIFIER_HI: begin
          read_byte = PART_CODE[15:8];
        end
        `CCR_ADDR_MAKER_IDENTIFIER_LO: begin
          read_byte = MAKER_CODE[7:0];
        end
        `CCR_ADDR_MAKER_IDENTIFIER_HI: begin
          read_byte = MAKER_CODE[15:8];
        end
        `CCR_ADDR_STREAMING_ADDRESS_CONTROL: begin
          read_byte = streaming_address_control;
        end
        `CCR_ADDR_ALIGNMENT_INPUT_CONTROL: begin
          read_byte = alignment_input_control;
        end
        `CCR_ADDR_ALIGNMENT_INPUT_OPTIONS: begin
          read_byte = alignment_input_options;
        end
        default: begin
          read_byte = 8'h00;
        end
      endcase
    end
  endfunction

  // ==========================================================
  // frame state machine
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (~spi_cs_n_in) begin
          next_state = ST_HEADER;
        end
      end
      ST_HEADER: begin
        if (spi_cs_n_in) begin
          next_state = ST_IDLE;
        end else if (header_done) begin
          next_state = ST_DATA;
        end
      end
      ST_DATA: begin
        if (spi_cs_n_in) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      state <= ST_IDLE;
      sclk_prev <= 1'b0;
      bit_cnt <= 5'd0;
      shift <= 16'h0000;
      read_op <= 1'b0;
      addr <= {`CCR_ADDR_W{1'b0}};
      rd_shift <= 8'h00;
      spi_sdo_out <= 1'b0;
    end else begin
      state <= next_state;
      sclk_prev <= spi_sclk_in;
      if (spi_cs_n_in) begin
        bit_cnt <= 5'd0;
      end else if (sclk_rise) begin
        shift <= shift_in;
        // data phase repeats byte after byte while select stays low
        if (byte_done) begin
          bit_cnt <= `CCR_HEADER_BITS;
        end else begin
          bit_cnt <= bit_cnt + 5'd1;
        end
      end
      if (header_done) begin
        read_op <= shift_in[`CCR_READ_FLAG_BIT];
        addr <= header_addr;
        rd_shift <= read_byte(header_addr);
      end else if (byte_done) begin
        addr <= next_addr;
        rd_shift <= read_byte(next_addr);
      end else if (sclk_fall & state[2]) begin
        // data leaves on the falling edge so the host samples it stable on the rising
        spi_sdo_out <= rd_shift[7];
        rd_shift <= {rd_shift[6:0], 1'b0};
      end
    end
  end

  // ==========================================================
  // register writes
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      config_a <= `CCR_RST_CONFIG_A;
      operating_mode_config <= `CCR_RST_OPERATING_MODE_CONFIG;
      class_reserved <= `CCR_RST_DEVICE_CLASS_HI;
      streaming_address_control <= `CCR_RST_STREAMING_ADDRESS_CONTROL;
      alignment_input_control <= `CCR_RST_ALIGNMENT_INPUT_CONTROL;
      alignment_input_options <= `CCR_RST_ALIGNMENT_INPUT_OPTIONS;
    end else if (do_write) begin
      case (addr)
        `CCR_ADDR_CONFIG_A: begin
          // soft reset is not served here; its bit and the fixed bit are dropped
          config_a <= wr_data & `CCR_CFGA_WRITE_MASK;
        end
        `CCR_ADDR_OPERATING_MODE_CONFIG: begin
          operating_mode_config <= wr_data;
        end
        `CCR_ADDR_DEVICE_CLASS_CODE: begin
          class_reserved <= wr_data[7:4];
        end
        `CCR_ADDR_STREAMING_ADDRESS_CONTROL: begin
          streaming_address_control <= wr_data;
        end
        `CCR_ADDR_ALIGNMENT_INPUT_CONTROL: begin
          // no ordering check: receiver-before-processor is left to the host
          alignment_input_control <= wr_data;
        end
        `CCR_ADDR_ALIGNMENT_INPUT_OPTIONS: begin
          alignment_input_options <= wr_data;
        end
        default: begin
          // identifier and unmapped addresses ignore writes
          config_a <= config_a;
        end
      endcase
    end
  end

  // ==========================================================
  // configuration outputs
  assign operating_mode_out = operating_mode_config[`CCR_MODE_MSB:`CCR_MODE_LSB];
  assign normal_operation_out = (operating_mode_out == `CCR_MODE_NORMAL);
  assign power_down_out = (operating_mode_out == `CCR_MODE_POWER_DOWN);
  assign reference_receiver_enable_out = alignment_input_control[`CCR_RECV_EN_BIT];
  assign reference_processor_enable_out = alignment_input_control[`CCR_PROC_EN_BIT];
  assign window_fine_scale_out = alignment_input_control[`CCR_FINE_SCALE_BIT];
  // zero here hands delay choice to the automatic calibration
  assign reference_delay_select_out =
    alignment_input_control[`CCR_DELAY_SEL_MSB:`CCR_DELAY_SEL_LSB];
  assign clock_input_dc_mode_out = alignment_input_options[`CCR_CLOCK_DC_MODE_BIT];
  assign reference_input_dc_mode_out = alignment_input_options[`CCR_REF_DC_MODE_BIT];

  // ==========================================================
  // reference path
  ccr_align_path u_align_path (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .reference_in(reference_in),
    .receiver_enable_in(reference_receiver_enable_out),
    .processor_enable_in(reference_processor_enable_out),
    .polarity_invert_in(alignment_input_options[`CCR_REF_INVERT_BIT]),
    .timestamp_enable_in(alignment_input_options[`CCR_TIMESTAMP_EN_BIT]),
    .general_timestamp_enable_in(general_timestamp_enable_in),
    .decimation_bypass_in(decimation_bypass_in),
    .sample_in(sample_in),
    .sample_out(sample_out),
    .reference_level_out(reference_level_out),
    .reference_event_out(reference_event_out)
  );

endmodule // ccr_regs
`default_nettype wire

/* ccr_consts.vh */
// constants of the converter configuration register bank
`ifndef CCR_CONSTS_VH
`define CCR_CONSTS_VH

// ==========================================================
// register byte addresses
`define CCR_ADDR_W 15
`define CCR_ADDR_CONFIG_A 15'h0000
`define CCR_ADDR_OPERATING_MODE_CONFIG 15'h0002
`define CCR_ADDR_DEVICE_CLASS_CODE 15'h0003
`define CCR_ADDR_PART_IDENTIFIER_LO 15'h0004
`define CCR_ADDR_PART_IDENTIFIER_HI 15'h0005
`define CCR_ADDR_MAKER_IDENTIFIER_LO 15'h000C
`define CCR_ADDR_MAKER_IDENTIFIER_HI 15'h000D
`define CCR_ADDR_STREAMING_ADDRESS_CONTROL 15'h0010
`define CCR_ADDR_ALIGNMENT_INPUT_CONTROL 15'h0029
`define CCR_ADDR_ALIGNMENT_INPUT_OPTIONS 15'h002A

// ==========================================================
// reset values
`define CCR_RST_CONFIG_A 8'h20
`define CCR_RST_OPERATING_MODE_CONFIG 8'h00
`define CCR_RST_DEVICE_CLASS_HI 4'h0
`define CCR_RST_STREAMING_ADDRESS_CONTROL 8'h00
`define CCR_RST_ALIGNMENT_INPUT_CONTROL 8'h00
`define CCR_RST_ALIGNMENT_INPUT_OPTIONS 8'h00

// ==========================================================
// field positions
`define CCR_CFGA_SOFT_RESET_BIT 7
`define CCR_CFGA_ADDR_ORDER_BIT 5
`define CCR_CFGA_SDO_ACTIVE_BIT 4
`define CCR_CFGA_WRITE_MASK 8'h6F
`define CCR_MODE_MSB 1
`define CCR_MODE_LSB 0
`define CCR_MODE_NORMAL 2'h0
`define CCR_MODE_POWER_DOWN 2'h3
`define CCR_ADDR_HOLD_BIT 0
`define CCR_PROC_EN_BIT 6
`define CCR_RECV_EN_BIT 5
`define CCR_FINE_SCALE_BIT 4
`define CCR_DELAY_SEL_MSB 3
`define CCR_DELAY_SEL_LSB 0
`define CCR_TIMESTAMP_EN_BIT 3
`define CCR_CLOCK_DC_MODE_BIT 2
`define CCR_REF_DC_MODE_BIT 1
`define CCR_REF_INVERT_BIT 0

// ==========================================================
// serial frame layout
`define CCR_HEADER_BITS 5'd16
`define CCR_FRAME_LAST_BIT 5'd23
`define CCR_READ_FLAG_BIT 15
`define CCR_SAMPLE_W 12

`endif

/* ccr_align_path.v */
// alignment reference input path: polarity, enables, timestamp insertion
`timescale 1ns/100ps
`default_nettype none
`include "ccr_consts.vh"

module ccr_align_path (
  input wire clk_in,
  input wire sys_rst_in,
  input wire reference_in,
  input wire receiver_enable_in,
  input wire processor_enable_in,
  input wire polarity_invert_in,
  input wire timestamp_enable_in,
  input wire general_timestamp_enable_in,
  input wire decimation_bypass_in,
  input wire [`CCR_SAMPLE_W-1:0] sample_in,
  output reg [`CCR_SAMPLE_W-1:0] sample_out,
  output reg reference_level_out,
  output reg reference_event_out
);

  wire next_level;
  wire insert;

  // receiver off holds the level low so no stray event reaches the processor
  assign next_level = receiver_enable_in & (reference_in ^ polarity_invert_in);
  // insertion needs both enables and a bypassed down-converter
  assign insert = timestamp_enable_in & general_timestamp_enable_in & decimation_bypass_in;

  // ==========================================================
  // registers
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      reference_level_out <= 1'b0;
      reference_event_out <= 1'b0;
      sample_out <= {`CCR_SAMPLE_W{1'b0}};
    end else begin
      reference_level_out <= next_level;
      reference_event_out <= processor_enable_in & next_level & ~reference_level_out;
      if (insert) begin
        sample_out <= {sample_in[`CCR_SAMPLE_W-1:1], next_level};
      end else begin
        sample_out <= sample_in;
      end
    end
  end

endmodule // ccr_align_path
`default_nettype wire

/* ccr_regs_assertions.sv */
// port checker for the converter configuration register bank
`timescale 1ns/100ps
`default_nettype none
`include "ccr_consts.vh"
module ccr_regs_checker (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sclk_in,
  input wire logic general_timestamp_enable_in,
  input wire logic decimation_bypass_in,
  input wire logic [`CCR_SAMPLE_W-1:0] sample_in,
  input wire logic [`CCR_SAMPLE_W-1:0] sample_out,
  input wire logic reference_level_out,
  input wire logic reference_event_out,
  input wire logic [1:0] operating_mode_out,
  input wire logic normal_operation_out,
  input wire logic power_down_out,
  input wire logic reference_receiver_enable_out,
  input wire logic reference_processor_enable_out,
  input wire logic [3:0] reference_delay_select_out,
  input wire logic clock_input_dc_mode_out,
  input wire logic reference_input_dc_mode_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // ==========================================================
  // assertions
  property p_normal;
    normal_operation_out == (operating_mode_out == 2'h0);
  endproperty
  a_normal: assert property (p_normal) else $error("normal decode wrong");
  property p_pdown;
    power_down_out == (operating_mode_out == 2'h3);
  endproperty
  a_pdown: assert property (p_pdown) else $error("power-down decode wrong");
  property p_level_off;
    !$past(reference_receiver_enable_out) |-> !reference_level_out;
  endproperty
  a_level_off: assert property (p_level_off) else $error("level with receiver off");
  property p_event_off;
    !$past(reference_processor_enable_out) |-> !reference_event_out;
  endproperty
  a_event_off: assert property (p_event_off) else $error("event with processor off");
  property p_event_pulse;
    reference_event_out |=> !reference_event_out;
  endproperty
  a_event_pulse: assert property (p_event_pulse) else $error("event longer than 1");
  property p_body;
    !$past(sys_rst_in) |-> sample_out[11:1] == $past(sample_in[11:1]);
  endproperty
  a_body: assert property (p_body) else $error("sample body not delayed copy");
  // insertion needs both device-wide enable and bypass
  property p_lsb;
    !$past(sys_rst_in) && !($past(general_timestamp_enable_in) && $past(decimation_bypass_in))
      |-> sample_out[0] == $past(sample_in[0]);
  endproperty
  a_lsb: assert property (p_lsb) else $error("lsb replaced without bypass");
  property p_sel_wr;
    $changed(reference_delay_select_out) && !$past(sys_rst_in)
      |-> !$past(spi_cs_n_in) && $past(spi_sclk_in);
  endproperty
  a_sel_wr: assert property (p_sel_wr) else $error("delay select moved off a write");
  property p_dc_idle;
    $past(spi_cs_n_in) && !$past(sys_rst_in)
      |-> $stable({clock_input_dc_mode_out, reference_input_dc_mode_out});
  endproperty
  a_dc_idle: assert property (p_dc_idle) else $error("dc mode moved while idle");
  c_pdown: cover property (power_down_out);
  c_event: cover property (reference_event_out);
  c_both_en: cover property (reference_receiver_enable_out && reference_processor_enable_out);
endmodule // ccr_regs_checker
bind ccr_regs ccr_regs_checker u_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
  .spi_cs_n_in(spi_cs_n_in), .spi_sclk_in(spi_sclk_in),
  .general_timestamp_enable_in(general_timestamp_enable_in),
  .decimation_bypass_in(decimation_bypass_in), .sample_in(sample_in), .sample_out(sample_out),
  .reference_level_out(reference_level_out), .reference_event_out(reference_event_out),
  .operating_mode_out(operating_mode_out), .normal_operation_out(normal_operation_out),
  .power_down_out(power_down_out),
  .reference_receiver_enable_out(reference_receiver_enable_out),
  .reference_processor_enable_out(reference_processor_enable_out),
  .reference_delay_select_out(reference_delay_select_out),
  .clock_input_dc_mode_out(clock_input_dc_mode_out),
  .reference_input_dc_mode_out(reference_input_dc_mode_out));
`default_nettype wire

/* ccr_host.sv */
// serial register host model driving the register port
`timescale 1ns/100ps
`default_nettype none
module ccr_host (
  input wire logic clk_in,
  input wire logic sdo_in,
  output logic cs_n_out,
  output logic sclk_out,
  output logic sdi_out
);
  logic [7:0] rx [4];
  // sclk stands low outside frames
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    sdi_out = 1'b0;
  end
  // two cycles low, two high: both at the two-period minimum
  task automatic sbit(input logic b, output logic r);
    @(posedge clk_in) sclk_out <= 1'b0;
    sdi_out <= b;
    @(posedge clk_in);
    @(posedge clk_in) sclk_out <= 1'b1;
    r = sdo_in;
    @(posedge clk_in);
  endtask
  task automatic frame(input logic rd, input logic [14:0] a, input int n, input logic [7:0] wd [4]);
    logic [15:0] hdr;
    logic r;
    hdr = {rd, a};
    @(posedge clk_in) cs_n_out <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sbit(hdr[i], r);
    end
    for (int j = 0; j < n; j++) begin
      for (int i = 7; i >= 0; i--) begin
        sbit(wd[j][i], r);
        rx[j][i] = r;
      end
    end
    @(posedge clk_in) sclk_out <= 1'b0;
    // released data line must not keep showing the last bit
    sdi_out <= ~sdi_out;
    @(posedge clk_in) cs_n_out <= 1'b1;
    @(posedge clk_in);
  endtask
endmodule // ccr_host
`default_nettype wire

/* tb_converter_config_regs.sv */
// testbench for the converter configuration register bank
`timescale 1ns/100ps
`default_nettype none
module tb_converter_config_regs;
  // arbitrary identification values
  localparam logic [3:0] CLS = 4'h9;
  localparam logic [15:0] PART = 16'h5AC3;
  localparam logic [15:0] MAKER = 16'hA53C;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic reference_in = 1'b0;
  logic general_timestamp_enable_in = 1'b0;
  logic decimation_bypass_in = 1'b0;
  logic [11:0] sample_in = 12'hAAA;
  logic [7:0] wb [4];
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  int ev_cnt = 0;
  wire logic spi_cs_n, spi_sclk, spi_sdi, spi_sdo;
  wire logic [11:0] sample_out;
  wire logic [1:0] operating_mode_out;
  wire logic [3:0] sel;
  wire logic ref_lvl, ref_ev, norm, pdown, recv, proc, fine, cdc, rdc;
  wire [15:0] cfg = {3'h0, operating_mode_out, norm, pdown, recv, proc, fine, sel, cdc, rdc};
  always #2.5 clk_in = ~clk_in;
  ccr_regs #(.CLASS_CODE(CLS), .PART_CODE(PART), .MAKER_CODE(MAKER)) DUT (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .spi_cs_n_in(spi_cs_n), .spi_sclk_in(spi_sclk),
    .spi_sdi_in(spi_sdi), .spi_sdo_out(spi_sdo), .reference_in(reference_in),
    .general_timestamp_enable_in(general_timestamp_enable_in),
    .decimation_bypass_in(decimation_bypass_in), .sample_in(sample_in), .sample_out(sample_out),
    .reference_level_out(ref_lvl), .reference_event_out(ref_ev),
    .operating_mode_out(operating_mode_out), .normal_operation_out(norm),
    .power_down_out(pdown), .reference_receiver_enable_out(recv),
    .reference_processor_enable_out(proc), .window_fine_scale_out(fine),
    .reference_delay_select_out(sel), .clock_input_dc_mode_out(cdc),
    .reference_input_dc_mode_out(rdc));
  ccr_host u_host (.clk_in(clk_in), .sdo_in(spi_sdo), .cs_n_out(spi_cs_n),
    .sclk_out(spi_sclk), .sdi_out(spi_sdi));
  // ==========================================================
  // helpers
  always @(posedge clk_in) begin
    if (ref_ev === 1'b1) ev_cnt++;
    cycles++;
    if (cycles == 40000) begin
      failures++;
      $display("MISMATCH t=%0t run too long", $time);
      end_of_test();
    end
  end
  task automatic end_of_test;
    if (failures == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic xf(input logic r, input logic [14:0] a, input int n, input logic [7:0] d0, d1, d2);
    wb[0] = d0;
    wb[1] = d1;
    wb[2] = d2;
    u_host.frame(r, a, n, wb);
  endtask
  task automatic rd(input logic [14:0] a, input int n, input logic [7:0] e0, e1, e2);
    logic [7:0] e [3];
    e = '{e0, e1, e2};
    xf(1'b1, a, n, 8'h00, 8'h00, 8'h00);
    for (int j = 0; j < n; j++) begin
      chk(u_host.rx[j], e[j]);
    end
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    chk(cfg, 16'h0400);
    chk({ref_lvl, ref_ev}, 2'h0);
    rd(15'h0000, 1, 8'h30, 8'h00, 8'h00);
    rd(15'h0002, 2, 8'h00, {4'h0, CLS}, 8'h00);
    rd(15'h0010, 1, 8'h00, 8'h00, 8'h00);
    rd(15'h0029, 2, 8'h00, 8'h00, 8'h00);
  endtask
  task automatic t_ids;
    rd(15'h0003, 3, {4'h0, CLS}, PART[7:0], PART[15:8]);
    rd(15'h000C, 2, MAKER[7:0], MAKER[15:8], 8'h00);
    xf(1'b0, 15'h0003, 3, 8'hFF, 8'h00, 8'h00);
    xf(1'b0, 15'h000C, 2, 8'h00, 8'h00, 8'h00);
    xf(1'b0, 15'h0007, 1, 8'h5A, 8'h00, 8'h00);
    rd(15'h0003, 3, {4'hF, CLS}, PART[7:0], PART[15:8]);
    rd(15'h000C, 2, MAKER[7:0], MAKER[15:8], 8'h00);
    rd(15'h0007, 1, 8'h00, 8'h00, 8'h00);
  endtask
  task automatic t_mode;
    for (int m = 0; m < 4; m++) begin
      xf(1'b0, 15'h0002, 1, {6'h15, m[1:0]}, 8'h00, 8'h00);
      chk(cfg[12:9], {m[1:0], m == 0, m == 3});
      rd(15'h0002, 1, {6'h15, m[1:0]}, 8'h00, 8'h00);
    end
    xf(1'b0, 15'h0002, 1, 8'h00, 8'h00, 8'h00);
  endtask
  task automatic t_stream;
    xf(1'b0, 15'h0029, 1, 8'h20, 8'h00, 8'h00);
    chk(cfg, 16'h0500);
    xf(1'b0, 15'h0029, 2, 8'h7A, 8'h06, 8'h00);
    chk(cfg, 16'h05EB);
    rd(15'h0029, 2, 8'h7A, 8'h06, 8'h00);
    xf(1'b0, 15'h0000, 1, 8'h00, 8'h00, 8'h00);
    xf(1'b0, 15'h002A, 2, 8'h09, 8'h35, 8'h00);
    chk(cfg, 16'h0554);
    rd(15'h0000, 1, 8'h10, 8'h00, 8'h00);
    rd(15'h002A, 2, 8'h09, 8'h35, 8'h00);
    xf(1'b0, 15'h0010, 1, 8'h01, 8'h00, 8'h00);
    xf(1'b0, 15'h0029, 3, 8'h11, 8'h22, 8'h60);
    chk(cfg, 16'h0580);
    rd(15'h002A, 2, 8'h09, 8'h09, 8'h00);
    xf(1'b0, 15'h0010, 1, 8'h00, 8'h00, 8'h00);
    xf(1'b0, 15'h0000, 1, 8'h20, 8'h00, 8'h00);
  endtask
  task automatic t_align;
    int e0;
    xf(1'b0, 15'h0029, 2, 8'h60, 8'h08, 8'h00);
    e0 = ev_cnt;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk_in) general_timestamp_enable_in <= k[1];
      decimation_bypass_in <= k[0];
      reference_in <= 1'b1;
      cyc(3);
      chk(sample_out, {sample_in[11:1], k == 3});
      chk(ref_lvl, 1'h1);
      @(posedge clk_in) reference_in <= 1'b0;
      cyc(3);
    end
    chk(ev_cnt - e0, 4);
    xf(1'b0, 15'h002A, 1, 8'h09, 8'h00, 8'h00);
    cyc(3);
    chk({ref_lvl, sample_out[0]}, 2'h3);
    xf(1'b0, 15'h0029, 1, 8'h20, 8'h00, 8'h00);
    e0 = ev_cnt;
    @(posedge clk_in) reference_in <= 1'b1;
    cyc(3);
    @(posedge clk_in) reference_in <= 1'b0;
    cyc(3);
    chk(ev_cnt - e0, 0);
    xf(1'b0, 15'h0029, 1, 8'h00, 8'h00, 8'h00);
    cyc(3);
    chk({ref_lvl, sample_out[0]}, 2'h0);
  endtask
  initial begin
    repeat (3) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    cyc(1);
    t_reset();
    t_ids();
    t_mode();
    t_stream();
    t_align();
    end_of_test();
  end
endmodule // tb_converter_config_regs
`default_nettype wire
